// *** rtl/cidp_pkg.sv ***
package cidp_pkg;

   // Register indexes of the transmit identifier bytes; the byte address is four times
   // the index, so each identifier byte sits alone in one aligned word.
   localparam logic [5:0] CIDP_OFS_TX_ID0   = 6'h00;
   localparam logic [5:0] CIDP_OFS_TX_ID1   = 6'h01;
   localparam logic [5:0] CIDP_OFS_TX_ID2   = 6'h02;
   localparam logic [5:0] CIDP_OFS_TX_ID3   = 6'h03;
   localparam logic [5:0] CIDP_OFS_RX_BASE  = 6'h10;
   localparam logic [5:0] CIDP_OFS_CTRL     = 6'h20;
   localparam logic [5:0] CIDP_OFS_STATUS   = 6'h24;

   // Field positions inside the identifier bytes.
   localparam int CIDP_SRR_POS  = 4;
   localparam int CIDP_IDE_POS  = 3;
   localparam int CIDP_RTR_POS  = 0;
   localparam int CIDP_STD_RTR_POS = 4;

   // Frame header widths.
   localparam int CIDP_EXT_ID_W   = 29;
   localparam int CIDP_STD_ID_W   = 11;
   localparam int CIDP_EXT_HDR_W  = 32;
   localparam int CIDP_STD_HDR_W  = 13;

   // Reset values of the register file.
   localparam logic [7:0] CIDP_BYTE_RST = 8'h00;

   // AXI response codes.
   localparam logic [1:0] CIDP_RESP_OKAY   = 2'h0;
   localparam logic [1:0] CIDP_RESP_SLVERR = 2'h2;

   // Serializer states.
   typedef enum logic [1:0] {CIDP_IDLE, CIDP_SHIFT} cidp_state_t;

endpackage

// *** rtl/cidp_top.sv ***
`timescale 1ns/1ps
// Functional notes
// - Extended header is 32 bits with flags.
// - Standard header is 13 bits with flags.
// - Identifier sent most significant bit first.
// - Smaller identifier value means higher priority.
// - Byte three holds bits six-zero plus RTR.
// - Received SRR stored exactly as sampled.
// - Received IDE reflects received frame format.
// - Transmit IDE selects standard or extended.
// - Received RTR reflects received frame value.
// - Transmit RTR selects data or remote frame.
module cidp_top
   import cidp_pkg::*;
(
   input  wire logic        clock,
   input  wire logic        arst_n,
   input  wire logic [5:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [5:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output logic             tx_bit,
   output logic             tx_bit_valid,
   output logic             tx_busy,
   input  wire logic        rx_bit,
   input  wire logic        rx_bit_valid,
   input  wire logic        rx_frame_start,
   input  wire logic        rx_frame_end,
   input  wire logic        arb_enable,
   input  wire logic [28:0] arb_other_id,
   output logic             arb_win
);

   ////////////////////////////////////////////////////////////////////////////
   // Register storage.
   // Everything here resets to zero, although software must not rely on it.

   // Identifier bytes: one set that software loads for sending, one that the
   // receive path fills at frame end and software only reads.
   logic [7:0]  tx_id_r [4];
   logic [7:0]  rx_id_r [4];
   logic [31:0] rx_shift_r;
   logic [5:0]  rx_cnt_r;
   logic        rx_full_r;
   logic        tx_start_r;
   // Bus side: one write is held until both of its halves have arrived.
   logic        aw_held_r;
   logic        w_held_r;
   logic [5:0]  aw_addr_r;
   logic [31:0] w_data_r;
   logic [3:0]  w_strb_r;
   // Header serializer state.
   cidp_state_t state_r;
   logic [31:0] tx_shift_r;
   logic [5:0]  tx_cnt_r;

   // Write decode. A write only takes effect once address and data are both
   // held and the previous response has been taken, so a slow master that
   // leaves bready low stalls the next write instead of losing its response.
   logic        wr_go;
   logic [3:0]  wr_idx;
   logic        wr_hit_tx;
   logic        wr_hit_ctrl;
   logic        wr_hit_stat;

   assign wr_go       = aw_held_r && w_held_r && !s_axi_bvalid;
   assign wr_idx      = aw_addr_r[5:2];
   assign wr_hit_tx   = (aw_addr_r[5:4] == 2'h0) && (aw_addr_r[1:0] == 2'h0);
   assign wr_hit_ctrl = (aw_addr_r == CIDP_OFS_CTRL);
   assign wr_hit_stat = (aw_addr_r == CIDP_OFS_STATUS);

   ////////////////////////////////////////////////////////////////////////////
   // Write address and data are caught independently, in either order.
   // While idle the ready toggles every cycle; a master that holds valid is
   // taken within two edges, at the cost of one cycle of latency at worst.

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         aw_held_r     <= 1'b0;
         aw_addr_r     <= 6'h00;
         s_axi_awready <= 1'b0;
      end else begin
         s_axi_awready <= !aw_held_r && !s_axi_awready;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_r     <= 1'b1;
            aw_addr_r     <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end else if (wr_go) begin
            aw_held_r <= 1'b0;
         end
      end
   end

   // Write data channel capture.
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         w_held_r     <= 1'b0;
         w_data_r     <= 32'h0000_0000;
         w_strb_r     <= 4'h0;
         s_axi_wready <= 1'b0;
      end else begin
         s_axi_wready <= !w_held_r && !s_axi_wready;
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_r     <= 1'b1;
            w_data_r     <= s_axi_wdata;
            w_strb_r     <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end else if (wr_go) begin
            w_held_r <= 1'b0;
         end
      end
   end

   // Write response; unmapped or read-only targets answer with a slave error.
   // The response stands until bready is seen, as the bus requires.
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= CIDP_RESP_OKAY;
      end else if (wr_go) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= (wr_hit_tx || wr_hit_ctrl || wr_hit_stat) ? CIDP_RESP_OKAY
                                                                   : CIDP_RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Transmit identifier bytes. Software is trusted to write SRR as one; the
   // byte is stored as written so a wrong value goes onto the bus visibly.
   // Writes during a transmission are dropped so the header cannot change.

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         for (int i = 0; i < 4; i++) begin
            tx_id_r[i] <= CIDP_BYTE_RST;
         end
      end else if (wr_go && wr_hit_tx && w_strb_r[0] && !tx_busy) begin
         tx_id_r[wr_idx[1:0]] <= w_data_r[7:0];
      end
   end

   // Control: bit 0 starts a transmission, ignored while one is running.
   // The start is a one-cycle pulse, so a stale control value never restarts.
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         tx_start_r <= 1'b0;
      end else begin
         tx_start_r <= wr_go && wr_hit_ctrl && w_strb_r[0] && w_data_r[0] && !tx_busy;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Header serializer. The header is assembled by format and shifted out
   // most significant bit first so identifier bit 28 (or 10) leads.

   logic [31:0] tx_hdr;
   logic        tx_ext;

   assign tx_ext = tx_id_r[1][CIDP_IDE_POS];
   // Extended: ID[28:18], SRR, IDE, ID[17:0], RTR (32 bits).
   // Standard: ID[10:0], RTR, IDE (13 bits), left aligned.
   assign tx_hdr = tx_ext ?
      {tx_id_r[0], tx_id_r[1][7:5], tx_id_r[1][CIDP_SRR_POS], tx_id_r[1][CIDP_IDE_POS],
       tx_id_r[1][2:0], tx_id_r[2], tx_id_r[3][7:1], tx_id_r[3][CIDP_RTR_POS]}
      : {tx_id_r[0], tx_id_r[1][7:5], tx_id_r[1][CIDP_STD_RTR_POS],
         tx_id_r[1][CIDP_IDE_POS], 19'h00000};
   // Standard frames leave the low 19 bits zero; they are never shifted out.

   // One header bit leaves per clock. Busy stays high until the cycle after
   // the last bit, so it covers every cycle in which tx_bit_valid is high.
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         state_r      <= CIDP_IDLE;
         tx_shift_r   <= 32'h0000_0000;
         tx_cnt_r     <= 6'h00;
         tx_bit       <= 1'b1;
         tx_bit_valid <= 1'b0;
         tx_busy      <= 1'b0;
      end else begin
         case (state_r)
            CIDP_IDLE: begin
               tx_bit       <= 1'b1;
               tx_bit_valid <= 1'b0;
               tx_busy      <= 1'b0;
               if (tx_start_r) begin
                  state_r    <= CIDP_SHIFT;
                  tx_shift_r <= tx_hdr;
                  tx_cnt_r   <= tx_ext ? 6'(CIDP_EXT_HDR_W) : 6'(CIDP_STD_HDR_W);
                  tx_busy    <= 1'b1;
               end
            end
            CIDP_SHIFT: begin
               tx_bit       <= tx_shift_r[31];
               tx_bit_valid <= 1'b1;
               tx_shift_r   <= {tx_shift_r[30:0], 1'b0};
               tx_cnt_r     <= tx_cnt_r - 6'h01;
               if (tx_cnt_r == 6'h01) begin
                  state_r <= CIDP_IDLE;
               end
            end
            default: begin
               state_r <= CIDP_IDLE;
               tx_busy <= 1'b0;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Arbitration compare: the lower identifier value wins the bus.

   // A standard identifier is compared zero-extended; frames of mixed format
   // are not ranked the way the bus itself would rank them.
   logic [28:0] own_id;

   assign own_id = tx_ext ? {tx_id_r[0], tx_id_r[1][7:5], tx_id_r[1][2:0], tx_id_r[2],
                             tx_id_r[3][7:1]}
                          : {18'h00000, tx_id_r[0], tx_id_r[1][7:5]};

   // The result stands one cycle after each request; a tie counts as a win.
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         arb_win <= 1'b0;
      end else begin
         arb_win <= arb_enable && (own_id <= arb_other_id);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Receive capture: bits arrive in bus order and are shifted in. At frame
   // end the header is unpacked by the IDE bit actually received.

   logic [7:0] rx_unp [4];
   logic       rx_ext;

   // Fewer than 32 bits at frame end can only be a standard header.
   // Extended IDE is bit 19 counting from the last of 32; standard IDE is bit 0 of 13.
   assign rx_ext = (rx_cnt_r == 6'(CIDP_EXT_HDR_W)) ? rx_shift_r[19] : 1'b0;

   // Unpack the captured header into the byte layout of its own format. SRR,
   // IDE and RTR are stored exactly as they arrived.
   always_comb begin
      if (rx_ext) begin
         rx_unp[0] = rx_shift_r[31:24];
         rx_unp[1] = {rx_shift_r[23:21], rx_shift_r[20], rx_shift_r[19], rx_shift_r[18:16]};
         rx_unp[2] = rx_shift_r[15:8];
         rx_unp[3] = rx_shift_r[7:0];
      end else begin
         rx_unp[0] = rx_shift_r[12:5];
         rx_unp[1] = {rx_shift_r[4:2], rx_shift_r[1], rx_shift_r[0], 3'h0};
         rx_unp[2] = 8'h00;
         rx_unp[3] = 8'h00;
      end
   end

   // The counter saturates at 32, so extra bits after an extended header are
   // ignored instead of pushing the identifier out of the shift register.
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         rx_shift_r <= 32'h0000_0000;
         rx_cnt_r   <= 6'h00;
      end else if (rx_frame_start) begin
         rx_cnt_r <= 6'h00;
      end else if (rx_bit_valid && rx_cnt_r != 6'(CIDP_EXT_HDR_W)) begin
         rx_shift_r <= {rx_shift_r[30:0], rx_bit};
         rx_cnt_r   <= rx_cnt_r + 6'h01;
      end
   end

   // Receive bytes and full flag; a new frame end wins over a software clear.
   // Losing the clear is safe: software sees the flag still set and reads again.
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         for (int i = 0; i < 4; i++) begin
            rx_id_r[i] <= CIDP_BYTE_RST;
         end
         rx_full_r <= 1'b0;
      end else if (rx_frame_end) begin
         for (int i = 0; i < 4; i++) begin
            rx_id_r[i] <= rx_unp[i];
         end
         rx_full_r <= 1'b1;
      end else if (wr_go && wr_hit_stat && w_strb_r[0] && w_data_r[1]) begin
         rx_full_r <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read channel: one cycle latency from address accept to data.
   // The address is decoded at the accept edge, so rdata shows the register
   // as it stood then, not at the later edge where rready is seen.

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= CIDP_RESP_OKAY;
      end else begin
         s_axi_arready <= !s_axi_rvalid && !s_axi_arready && !s_axi_arvalid ? 1'b1
                          : (!s_axi_rvalid && !s_axi_arready);
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= CIDP_RESP_OKAY;
            if (s_axi_araddr[5:4] == 2'h0 && s_axi_araddr[1:0] == 2'h0) begin
               s_axi_rdata <= {24'h000000, tx_id_r[s_axi_araddr[3:2]]};
            end else if (s_axi_araddr[5:4] == CIDP_OFS_RX_BASE[5:4]
                         && s_axi_araddr[1:0] == 2'h0) begin
               s_axi_rdata <= {24'h000000, rx_id_r[s_axi_araddr[3:2]]};
            end else if (s_axi_araddr == CIDP_OFS_CTRL) begin
               s_axi_rdata <= 32'h0000_0000;
            end else if (s_axi_araddr == CIDP_OFS_STATUS) begin
               s_axi_rdata <= {30'h00000000, rx_full_r, tx_busy};
            end else begin
               s_axi_rdata <= 32'h0000_0000;
               s_axi_rresp <= CIDP_RESP_SLVERR;
            end
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

endmodule

// *** test/cidp_chk.sv ***
`timescale 1ns/1ps
module cidp_chk (
   input wire logic        clock,
   input wire logic        arst_n,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic        s_axi_rvalid,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        tx_bit,
   input wire logic        tx_bit_valid,
   input wire logic        tx_busy,
   input wire logic        arb_enable,
   input wire logic        arb_win
);
   logic [5:0] run_r;
   default clocking @(posedge clock); endclocking
   default disable iff (!arst_n);
   // Length of the current bit run, judged at the cycle the run ends.
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         run_r <= 6'h00;
      end else begin
         run_r <= tx_bit_valid ? run_r + 6'h01 : 6'h00;
      end
   end
   ////////////////////////////////////////
   chk_frame_len: assert property ($fell(tx_bit_valid) |-> run_r inside {6'h0D, 6'h20})
      else $error("header length is neither 13 nor 32 bits");
   chk_bits_busy: assert property (tx_bit_valid |-> tx_busy)
      else $error("header bit outside busy");
   chk_busy_lead: assert property ($rose(tx_busy) |=> tx_bit_valid)
      else $error("first header bit late");
   // The thirteenth bit is the format flag, so it decides whether the run goes on.
   chk_ide_len: assert property (tx_bit_valid && run_r == 6'h0C |=> tx_bit_valid == $past(tx_bit))
      else $error("format flag and header length disagree");
   chk_busy_ends: assert property ($fell(tx_bit_valid) |-> ##[0:2] !tx_busy)
      else $error("busy outlasts the header");
   chk_arb_cause: assert property (arb_win |-> $past(arb_enable))
      else $error("arbitration won without a request");
   chk_read_ans: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   chk_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
      else $error("upper read data not zero");
endmodule
bind cidp_top cidp_chk u_chk (.clock, .arst_n, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
   .s_axi_rdata, .tx_bit, .tx_bit_valid, .tx_busy, .arb_enable, .arb_win);

// *** test/cidp_peer.sv ***
`timescale 1ns/1ps
module cidp_peer (
   input  wire logic clock,
   output logic      rx_bit,
   output logic      rx_bit_valid,
   output logic      rx_frame_start,
   output logic      rx_frame_end
);
   // Quiet bus at start: no markers, no header bits.
   initial begin
      rx_bit = 1'b1;
      rx_bit_valid = 1'b0;
      rx_frame_start = 1'b0;
      rx_frame_end = 1'b0;
   end
   // Sends the n low header bits oldest first; between bits the line shows the inverse.
   task automatic send(input logic [31:0] hdr, input int n, input int gap);
      @(posedge clock);
      rx_frame_start <= 1'b1;
      @(posedge clock);
      rx_frame_start <= 1'b0;
      for (int i = n - 1; i >= 0; i--) begin
         rx_bit <= hdr[i];
         rx_bit_valid <= 1'b1;
         @(posedge clock);
         if (gap > 0 && i > 0) begin
            rx_bit <= ~hdr[i];
            rx_bit_valid <= 1'b0;
            repeat (gap) @(posedge clock);
         end
      end
      rx_bit <= ~hdr[0];
      rx_bit_valid <= 1'b0;
      rx_frame_end <= 1'b1;
      @(posedge clock);
      rx_frame_end <= 1'b0;
   endtask
endmodule

// *** test/cidp_tb_top.sv ***
`timescale 1ns/1ps
module cidp_tb_top
   import cidp_pkg::*;
;
   logic        clock = 1'b0;
   logic        arst_n = 1'b0;
   logic [5:0]  s_axi_awaddr = 6'h00;
   logic        s_axi_awvalid = 1'b0;
   logic        s_axi_awready;
   logic [31:0] s_axi_wdata = 32'h00000000;
   logic [3:0]  s_axi_wstrb = 4'hF;
   logic        s_axi_wvalid = 1'b0;
   logic        s_axi_wready;
   logic [1:0]  s_axi_bresp;
   logic        s_axi_bvalid;
   logic        s_axi_bready = 1'b0;
   logic [5:0]  s_axi_araddr = 6'h00;
   logic        s_axi_arvalid = 1'b0;
   logic        s_axi_arready;
   logic [31:0] s_axi_rdata;
   logic [1:0]  s_axi_rresp;
   logic        s_axi_rvalid;
   logic        s_axi_rready = 1'b0;
   logic        tx_bit, tx_bit_valid, tx_busy, arb_win;
   logic        rx_bit, rx_bit_valid, rx_frame_start, rx_frame_end;
   logic        arb_enable = 1'b0;
   logic [28:0] arb_other_id = 29'h00000000;
   int          err_count = 0;
   int          n_checks = 0;
   int          seed = 61001;
   logic        txq[$];

   cidp_top dut (.clock, .arst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .tx_bit, .tx_bit_valid, .tx_busy, .rx_bit, .rx_bit_valid,
      .rx_frame_start, .rx_frame_end, .arb_enable, .arb_other_id, .arb_win);
   cidp_peer peer (.clock, .rx_bit, .rx_bit_valid, .rx_frame_start, .rx_frame_end);

   // Free-running clock; every header bit on the wire is logged.
   always #10 clock = ~clock;
   always @(posedge clock) if (tx_bit_valid) txq.push_back(tx_bit);
   ////////////////////////////////////////
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Address and data offered together and each released once taken.
   task automatic axw(input logic [5:0] a, input logic [31:0] d, input logic [1:0] er);
      int t = 0;
      @(posedge clock);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge clock);
         t++;
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1 && t < 50);
      s_axi_bready <= 1'b0;
      if (s_axi_bvalid !== 1'b1) err_count++;
      chk(32'(s_axi_bresp), 32'(er));
   endtask
   task automatic axr(input logic [5:0] a, input logic [31:0] e, input logic [1:0] er);
      int t = 0;
      @(posedge clock);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge clock);
         t++;
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1 && t < 50);
      s_axi_rready <= 1'b0;
      if (s_axi_rvalid !== 1'b1) err_count++;
      chk(s_axi_rdata, e);
      chk(32'(s_axi_rresp), 32'(er));
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   ////////////////////////////////////////
   // Each pass covers one format and frame kind: transmit, arbitrate, then receive.
   initial begin
      logic [7:0]  b0, b1, b2, b3;
      logic [31:0] hdr, by, sv;
      logic [28:0] own;
      int          n;
      repeat (2) @(posedge clock);
      arst_n <= 1'b1;
      axr(6'(4 * CIDP_OFS_TX_ID0), 32'h0, CIDP_RESP_OKAY);
      axr(6'h28, 32'h0, CIDP_RESP_SLVERR);
      for (int k = 0; k < 4; k++) begin
         {b0, b1, b2, b3} = $random(seed);
         b1[3] = k[0];
         b1[4] = k[0] ? 1'b1 : k[1];
         b3[0] = k[1];
         by = {b0, b1, b2, b3};
         hdr = k[0] ? by : {19'h0, b0, b1[7:3]};
         n = k[0] ? 32 : 13;
         own = k[0] ? {b0, b1[7:5], b1[2:0], b2, b3[7:1]} : {18'h0, b0, b1[7:5]};
         for (int j = 0; j < 4; j++) begin
            axw(6'(4 * j), {24'h0, by[31 - 8 * j -: 8]}, CIDP_RESP_OKAY);
            axr(6'(4 * j), {24'h0, by[31 - 8 * j -: 8]}, CIDP_RESP_OKAY);
         end
         // A write with lane 0 disabled must leave the byte alone.
         s_axi_wstrb <= 4'hE;
         axw(6'(4 * CIDP_OFS_TX_ID2), {24'h0, ~b2}, CIDP_RESP_OKAY);
         s_axi_wstrb <= 4'hF;
         axr(6'(4 * CIDP_OFS_TX_ID2), {24'h0, b2}, CIDP_RESP_OKAY);
         txq.delete();
         axw(CIDP_OFS_CTRL, 32'h1, CIDP_RESP_OKAY);
         axw(6'(4 * CIDP_OFS_TX_ID0), {24'h0, ~b0}, CIDP_RESP_OKAY);
         axr(CIDP_OFS_STATUS, 32'h1, CIDP_RESP_OKAY);
         for (int t = 0; t < 100 && tx_busy !== 1'b0; t++) @(posedge clock);
         chk(32'(tx_busy), 32'h0);
         sv = 32'h0;
         foreach (txq[i]) sv = {sv[30:0], txq[i]};
         chk(32'(txq.size()), 32'(n));
         chk(sv, hdr);
         axr(6'(4 * CIDP_OFS_TX_ID0), {24'h0, b0}, CIDP_RESP_OKAY);
         for (int d = -1; d < 2; d++) begin
            arb_other_id <= own + 29'(d);
            arb_enable <= 1'b1;
            @(posedge clock);
            arb_enable <= 1'b0;
            @(posedge clock);
            chk(32'(arb_win), 32'(own <= own + 29'(d)));
         end
         hdr = $random(seed);
         if (k[0]) hdr[19] = 1'b1;
         else hdr = {19'h0, hdr[12:1], 1'b0};
         peer.send(hdr, n, k[1] ? 2 : 0);
         by = k[0] ? hdr : {hdr[12:5], hdr[4:0], 3'h0, 16'h0};
         for (int j = 0; j < 4; j++) begin
            axr(CIDP_OFS_RX_BASE + 6'(4 * j), {24'h0, by[31 - 8 * j -: 8]}, CIDP_RESP_OKAY);
         end
         axr(CIDP_OFS_STATUS, 32'h2, CIDP_RESP_OKAY);
         axw(CIDP_OFS_RX_BASE, 32'hFF, CIDP_RESP_SLVERR);
         axw(CIDP_OFS_STATUS, 32'h2, CIDP_RESP_OKAY);
         axr(CIDP_OFS_STATUS, 32'h0, CIDP_RESP_OKAY);
      end
      report_and_stop();
   end
   // Cuts a hang short well after the expected run length.
   initial begin
      repeat (8000) @(posedge clock);
      err_count++;
      report_and_stop();
   end
endmodule
